/* design/rcst_top.sv */
// Reset sequencer: merges reset requests, times start-up, keeps cause flags.
// Assumes supply monitor, pin, watchdog and wake inputs are synchronous to clk.
//
// Notes on behaviour
// - Six distinct reset causes are recognised
// - Resets load defaults; watchdog wake keeps them
// - Short reset-pin glitches are filtered out
// - Watchdog reset never drives the pin
// - Internal-reset option ignores pin, no pull-up
// - Power-on holds reset until supply good
// - 72 ms delay only after power-on/brown-out
// - Delay-enable config bit is active low
// - 1024 oscillator cycles follow the delay
// - Start-up count: crystal modes, power-on/brown-out/wake only
// - Qualified brown-out resets when detection enabled
// - Hold reset until supply above brown-out
// - Brown-out skips delay when delay disabled
// - Brown-out during delay restarts full delay
// - Delay then count; none for external clock
// - Delays timed from power-on, not pin
// - Delay combinations follow the mode table
// - Power-on clears power flag; software sets it
// - Brown-out clears brown-out flag; software sets it (code clears it only for a brown-out seen in ST_RUN)
// - Time-out/power-down flags follow the cause table
// - Reset loads PC zero; wakes continue, vector
// - Interrupt wake sets the waking peripheral flag
// - Codes 000, 001, 010 are crystal modes
`timescale 1ns/1ns

module rcst_top (
	input  wire logic                  clk,
	input  wire logic                  sys_rst,
	input  wire rcst_pkg::rcst_wb_req_t wbReq,
	output rcst_pkg::rcst_wb_rsp_t      wbRsp,
	input  wire rcst_pkg::rcst_cfg_t   cfg,
	input  wire logic                  supplyPowerOk,
	input  wire logic                  belowBrownoutThreshold,
	input  wire logic                  ext_reset_n,
	input  wire logic                  watchdogTimeout,
	input  wire logic                  sleeping,
	input  wire logic                  oscTick,
	input  wire logic                  irqWake,
	input  wire logic [3:0]            irqWakeSource,
	input  wire logic                  global_irq_enable,
	input  wire logic [12:0]           sleepPc,
	output logic                       coreReset,
	output logic                       resumeWake,
	output logic [12:0]                pcLoad,
	output logic                       pcLoadValid,
	output logic [7:0]                 peripheralFlags,
	output logic                       extPinDriveOe
);

	typedef enum logic [2:0] {
		ST_PORHOLD,
		ST_BODHOLD,
		ST_POWERUP_DELAY_TIMER,
		ST_OST,
		ST_PINWAIT,
		ST_RUN
	} state_t;

	state_t      state_r;
	logic [19:0] cnt_r;
	logic [10:0] oscCnt_r;
	logic [2:0]  glitch_r;
	logic        pinLow_r;
	logic [7:0]  status_r;
	logic [1:0]  power_control_flags_r;
	logic [2:0]  cause_r;
	logic        wakeOst_r;
	logic        brownoutQual;
	logic        pinAsserted;
	logic        wbHit;
	logic        wbCommit;
	logic        wakeNeedsOst;
	logic [31:0] rdData;

	// Crystal modes need the oscillator start-up count
	function automatic logic isCrystal(input logic [2:0] osc);
		return (osc == rcst_pkg::RCST_OSC_LP) || (osc == rcst_pkg::RCST_OSC_XT) ||
			(osc == rcst_pkg::RCST_OSC_HS);
	endfunction

	localparam logic [19:0] POWERUP_DELAY_TIMER_LAST = 20'(rcst_pkg::RCST_POWERUP_DELAY_TIMER_CYCLES - 1);
	localparam logic [10:0] OST_DONE  = 11'(rcst_pkg::RCST_OST_PERIODS);
	localparam logic [2:0]  GLITCH_N  = 3'(rcst_pkg::RCST_GLITCH_CYCLES);

	assign brownoutQual = cfg.brownoutDetectEnable && belowBrownoutThreshold;
	// Pin tied inactive when the internal-reset option is chosen
	assign pinAsserted  = cfg.extResetPinSelect && pinLow_r;
	assign wakeNeedsOst = isCrystal(cfg.oscSelect);
	assign wbHit        = wbReq.cyc && wbReq.stb && !wbRsp.ack;
	// Writes land on the edge where the master sees ack, not before
	assign wbCommit     = wbReq.cyc && wbReq.stb && wbRsp.ack && wbReq.we;

	// Glitch filter: pin must stay low for several cycles to count
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			glitch_r <= 3'h0;
			pinLow_r <= 1'b0;
		end else if (ext_reset_n) begin
			glitch_r <= 3'h0;
			pinLow_r <= 1'b0;
		end else if (glitch_r != GLITCH_N) begin
			glitch_r <= glitch_r + 3'h1;
		end else begin
			pinLow_r <= 1'b1;
		end
	end

	// Sequencer; sys_rst stands in for the power-on pulse
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r      <= ST_PORHOLD;
			cnt_r        <= 20'h0;
			oscCnt_r     <= 11'h0;
		end else begin
			case (state_r)
				ST_PORHOLD: begin
					cnt_r    <= 20'h0;
					oscCnt_r <= 11'h0;
					// Power-on does not re-trigger on a falling supply
					if (supplyPowerOk && !brownoutQual) begin
						if (!cfg.powerupDelayEnableN)
							state_r <= ST_POWERUP_DELAY_TIMER;
						else if (isCrystal(cfg.oscSelect))
							state_r <= ST_OST;
						else
							state_r <= ST_PINWAIT;
					end
				end
				ST_BODHOLD: begin
					cnt_r    <= 20'h0;
					oscCnt_r <= 11'h0;
					if (!brownoutQual) begin
						// Brown-out delay skipped when the delay bit is set
						if (!cfg.powerupDelayEnableN)
							state_r <= ST_POWERUP_DELAY_TIMER;
						else if (isCrystal(cfg.oscSelect))
							state_r <= ST_OST;
						else
							state_r <= ST_PINWAIT;
					end
				end
				ST_POWERUP_DELAY_TIMER: begin
					if (brownoutQual) begin
						state_r <= ST_BODHOLD;
					end else if (cnt_r == POWERUP_DELAY_TIMER_LAST) begin
						cnt_r <= 20'h0;
						// Crystal modes add the count after power-on and brown-out alike
						if (isCrystal(cfg.oscSelect))
							state_r <= ST_OST;
						else
							state_r <= ST_PINWAIT;
					end else begin
						cnt_r <= cnt_r + 20'h1;
					end
				end
				ST_OST: begin
					if (brownoutQual)
						state_r <= ST_BODHOLD;
					else if (oscCnt_r == OST_DONE)
						state_r <= ST_PINWAIT;
					else if (oscTick)
						oscCnt_r <= oscCnt_r + 11'h1;
				end
				ST_PINWAIT: begin
					// Delays already expired: run as soon as the pin lets go
					if (brownoutQual)
						state_r <= ST_BODHOLD;
					else if (!pinAsserted)
						state_r <= ST_RUN;
				end
				ST_RUN: begin
					if (brownoutQual)
						state_r <= ST_BODHOLD;
					else if (pinAsserted || (watchdogTimeout && !sleeping))
						state_r <= ST_PINWAIT;
					else if (sleeping && (irqWake || watchdogTimeout) && wakeNeedsOst) begin
						oscCnt_r <= 11'h0;
						state_r  <= ST_OST;
					end
				end
				default: state_r <= ST_PORHOLD;
			endcase
		end
	end

	// Cause, status and power flags; software writes lose to hardware events
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_r <= rcst_pkg::RCST_STATUS_RST;
			power_control_flags_r   <= rcst_pkg::RCST_POWER_CONTROL_FLAGS_RST;
			cause_r  <= 3'(rcst_pkg::RCST_CAUSE_POR);
		end else begin
			if (wbCommit && wbReq.sel[0]) begin
				if (wbReq.adr[7:0] == rcst_pkg::RCST_IDX_STATUS)
					status_r[2:0] <= wbReq.dat[2:0];
				if (wbReq.adr[7:0] == rcst_pkg::RCST_IDX_POWER_CONTROL_FLAGS)
					power_control_flags_r <= wbReq.dat[1:0];
			end
			if (state_r == ST_RUN) begin
				if (brownoutQual) begin
					power_control_flags_r[rcst_pkg::RCST_BIT_BOD]  <= 1'b0;
					power_control_flags_r[rcst_pkg::RCST_BIT_POR]  <= 1'b1;
					status_r[rcst_pkg::RCST_BIT_TO] <= 1'b1;
					status_r[rcst_pkg::RCST_BIT_PD] <= 1'b1;
					cause_r <= 3'(rcst_pkg::RCST_CAUSE_BOD);
				end else if (pinAsserted && sleeping) begin
					status_r[rcst_pkg::RCST_BIT_TO] <= 1'b1;
					status_r[rcst_pkg::RCST_BIT_PD] <= 1'b0;
					cause_r <= 3'(rcst_pkg::RCST_CAUSE_PIN_SLEEP);
				end else if (pinAsserted) begin
					cause_r <= 3'(rcst_pkg::RCST_CAUSE_PIN_RUN);
				end else if (watchdogTimeout && sleeping) begin
					status_r[rcst_pkg::RCST_BIT_TO] <= 1'b0;
					status_r[rcst_pkg::RCST_BIT_PD] <= 1'b0;
					cause_r <= 3'(rcst_pkg::RCST_CAUSE_WDT_SLEEP);
				end else if (watchdogTimeout) begin
					status_r[rcst_pkg::RCST_BIT_TO] <= 1'b0;
					cause_r <= 3'(rcst_pkg::RCST_CAUSE_WDT_RUN);
				end else if (irqWake && sleeping) begin
					status_r[rcst_pkg::RCST_BIT_TO] <= 1'b1;
					status_r[rcst_pkg::RCST_BIT_PD] <= 1'b0;
				end
			end
		end
	end

	// Program counter load and peripheral wake flags
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pcLoad          <= rcst_pkg::RCST_PC_RESET;
			pcLoadValid     <= 1'b0;
			resumeWake      <= 1'b0;
			peripheralFlags <= 8'h00;
			wakeOst_r       <= 1'b0;
		end else begin
			pcLoadValid <= 1'b0;
			resumeWake  <= 1'b0;
			// A brown-out turns a pending wake into a full reset
			if (state_r == ST_BODHOLD)
				wakeOst_r <= 1'b0;
			if (state_r == ST_PINWAIT && !pinAsserted && !brownoutQual) begin
				// A wake that waited for the crystal keeps its resume address
				if (!wakeOst_r)
					pcLoad <= rcst_pkg::RCST_PC_RESET;
				pcLoadValid <= 1'b1;
				wakeOst_r   <= 1'b0;
			end else if (state_r == ST_RUN && sleeping && !pinAsserted && !brownoutQual &&
				(irqWake || watchdogTimeout)) begin
				// Wake-up is resumption: no register defaults applied
				resumeWake  <= 1'b1;
				pcLoadValid <= !wakeNeedsOst;
				wakeOst_r   <= wakeNeedsOst;
				if (irqWake && !watchdogTimeout && global_irq_enable)
					pcLoad <= rcst_pkg::RCST_PC_VECTOR;
				else
					pcLoad <= 13'(sleepPc + 13'h1);
				if (irqWake && !watchdogTimeout) begin
					peripheralFlags[rcst_pkg::RCST_BIT_EEIF] <= irqWakeSource[3];
					peripheralFlags[rcst_pkg::RCST_BIT_ADIF] <= irqWakeSource[2];
					peripheralFlags[rcst_pkg::RCST_BIT_CMIF] <= irqWakeSource[1];
					peripheralFlags[rcst_pkg::RCST_BIT_T1IF] <= irqWakeSource[0];
				end
			end
		end
	end

	// Internal reset, released on a clock edge
	always_ff @(posedge clk) begin
		if (sys_rst)
			coreReset <= 1'b1;
		else
			coreReset <= (state_r != ST_RUN) ||
				(brownoutQual || pinAsserted || (watchdogTimeout && !sleeping));
	end

	// The pin is never driven; watchdog reset stays internal
	always_ff @(posedge clk) begin
		extPinDriveOe <= 1'b0;
	end

	// Read mux
	always_comb begin
		rdData = 32'h0;
		case (wbReq.adr[7:0])
			rcst_pkg::RCST_IDX_STATUS: rdData = {24'h0, status_r};
			rcst_pkg::RCST_IDX_POWER_CONTROL_FLAGS:   rdData = {30'h0, power_control_flags_r};
			rcst_pkg::RCST_IDX_CTRL:   rdData = {26'h0, cfg};
			rcst_pkg::RCST_IDX_CAUSE:  rdData = {29'h0, cause_r};
			rcst_pkg::RCST_IDX_PC:     rdData = {19'h0, pcLoad};
			default:                   rdData = 32'h0;
		endcase
	end

	// Wishbone answer one cycle after request; unmapped reads zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wbRsp <= '0;
		end else begin
			wbRsp.ack <= wbHit;
			wbRsp.dat <= wbHit ? rdData : 32'h0;
		end
	end

	a_pin_never_driven: assert property (@(posedge clk) disable iff (sys_rst)
		!extPinDriveOe) else $error("reset pin driven");

	a_glitch_ignored: assert property (@(posedge clk) disable iff (sys_rst)
		$fell(ext_reset_n) ##1 ext_reset_n |-> !pinLow_r) else $error("glitch caused reset");

	a_pin_masked: assert property (@(posedge clk) disable iff (sys_rst)
		!cfg.extResetPinSelect |-> !pinAsserted) else $error("pin acted while masked");

	a_bod_restart: assert property (@(posedge clk) disable iff (sys_rst)
		(state_r == ST_POWERUP_DELAY_TIMER && brownoutQual) |=> state_r == ST_BODHOLD) else $error("no restart");

	a_reset_in_delay: assert property (@(posedge clk) disable iff (sys_rst)
		state_r == ST_POWERUP_DELAY_TIMER |=> coreReset) else $error("left reset during delay");

	a_no_delay_disabled: assert property (@(posedge clk) disable iff (sys_rst)
		(state_r == ST_BODHOLD && cfg.powerupDelayEnableN && !brownoutQual)
		|=> state_r != ST_POWERUP_DELAY_TIMER) else $error("delay ran while disabled");

	a_bod_flag_clear: assert property (@(posedge clk) disable iff (sys_rst)
		(state_r == ST_RUN && brownoutQual) |=> !power_control_flags_r[rcst_pkg::RCST_BIT_BOD]) else $error("brown-out flag");

	a_wdt_to_clear: assert property (@(posedge clk) disable iff (sys_rst)
		(state_r == ST_RUN && watchdogTimeout && !brownoutQual && !pinAsserted)
		|=> !status_r[rcst_pkg::RCST_BIT_TO]) else $error("time-out flag not cleared");

	a_reset_pc_zero: assert property (@(posedge clk) disable iff (sys_rst)
		(state_r == ST_PINWAIT && !pinAsserted && !brownoutQual && !wakeOst_r)
		|=> pcLoadValid && pcLoad == rcst_pkg::RCST_PC_RESET ##1 !coreReset) else $error("reset PC");

endmodule

/* inc/rcst_pkg.sv */
// Package for the reset cause and start-up timer block.
// Assumes a 10 MHz system clock and a classic Wishbone register bus.
package rcst_pkg;

	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] RCST_IDX_STATUS = 8'h03;
	localparam logic [7:0] RCST_IDX_POWER_CONTROL_FLAGS   = 8'h8e;
	localparam logic [7:0] RCST_IDX_CTRL   = 8'hc0;
	localparam logic [7:0] RCST_IDX_CAUSE  = 8'hc1;
	localparam logic [7:0] RCST_IDX_PC     = 8'hc2;

	// Field positions
	localparam int RCST_BIT_TO    = 4;
	localparam int RCST_BIT_PD    = 3;
	localparam int RCST_BIT_POR   = 1;
	localparam int RCST_BIT_BOD   = 0;
	localparam int RCST_BIT_EEIF  = 7;
	localparam int RCST_BIT_ADIF  = 6;
	localparam int RCST_BIT_CMIF  = 3;
	localparam int RCST_BIT_T1IF  = 0;

	// Reset values
	localparam logic [7:0] RCST_STATUS_RST = 8'h18;
	localparam logic [1:0] RCST_POWER_CONTROL_FLAGS_RST   = 2'h0;

	// Program counter targets
	localparam logic [12:0] RCST_PC_RESET  = 13'h0000;
	localparam logic [12:0] RCST_PC_VECTOR = 13'h0004;

	// Oscillator-select codes that need the start-up count
	localparam logic [2:0] RCST_OSC_LP = 3'h0;
	localparam logic [2:0] RCST_OSC_XT = 3'h1;
	localparam logic [2:0] RCST_OSC_HS = 3'h2;

	// Timing
	localparam int RCST_CLK_HZ        = 10000000;
	localparam int RCST_POWERUP_DELAY_TIMER_MS       = 72;
	localparam int RCST_POWERUP_DELAY_TIMER_CYCLES   = (RCST_POWERUP_DELAY_TIMER_MS * (RCST_CLK_HZ / 1000));
	localparam int RCST_OST_PERIODS   = 1024;
	localparam int RCST_GLITCH_CYCLES = 4;

	// Wishbone slave request and answer
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [9:0]  adr;
		logic [31:0] dat;
	} rcst_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} rcst_wb_rsp_t;

	// Configuration word fields
	typedef struct packed {
		logic       brownoutDetectEnable;
		logic       extResetPinSelect;
		logic       powerupDelayEnableN;
		logic [2:0] oscSelect;
	} rcst_cfg_t;

	// Reset cause codes
	typedef enum logic [2:0] {
		RCST_CAUSE_NONE,
		RCST_CAUSE_POR,
		RCST_CAUSE_WDT_RUN,
		RCST_CAUSE_WDT_SLEEP,
		RCST_CAUSE_PIN_RUN,
		RCST_CAUSE_PIN_SLEEP,
		RCST_CAUSE_BOD
	} rcst_cause_t;

endpackage

/* sim/rcst_far_side.sv */
// Far-side model: supply monitors, unfiltered reset pin source and crystal.
// Assumes the bench commands supply and pin levels synchronously to clk.
`timescale 1ns/1ns

module rcst_far_side #(
	parameter int OSC_DIV = 2
) (
	input  wire logic clk,
	input  wire logic supplyCmd,
	input  wire logic brownCmd,
	input  wire logic pinCmd,
	output logic      supplyPowerOk,
	output logic      belowBrownoutThreshold,
	output logic      ext_reset_n,
	output logic      oscTick
);
	int divCnt = 0;

	// Monitors lag the command by one cycle, like a slow comparator
	always @(posedge clk) begin
		supplyPowerOk <= supplyCmd;
		belowBrownoutThreshold <= brownCmd; // Already qualified by time
		ext_reset_n <= pinCmd;
	end

	// Crystal runs free, so ticks keep coming during reset and sleep
	always @(posedge clk) begin
		divCnt <= (divCnt == OSC_DIV - 1) ? 0 : divCnt + 1;
		oscTick <= (divCnt == 0);
	end
endmodule

/* sim/rcst_tb_top.sv */
// Self-checking bench for the reset sequencer, random and corner stimulus.
// Assumes 10 MHz; the long power-up delay stays disabled to keep runs short.
`timescale 1ns/1ns

module rcst_tb_top;
	localparam int OSC_STARTUP_COUNTER = rcst_pkg::RCST_OST_PERIODS * 2;
	localparam logic [7:0] STA = rcst_pkg::RCST_IDX_STATUS;
	localparam logic [7:0] PCN = rcst_pkg::RCST_IDX_POWER_CONTROL_FLAGS;
	logic                   clk = 1'b0;
	logic                   sys_rst = 1'b1;
	rcst_pkg::rcst_wb_req_t wbReq = '0;
	rcst_pkg::rcst_wb_rsp_t wbRsp;
	rcst_pkg::rcst_cfg_t    cfg = '{1'b1, 1'b1, 1'b1, rcst_pkg::RCST_OSC_XT};
	logic supplyCmd = 1'b0, brownCmd = 1'b0, pinCmd = 1'b1, watchdogTimeout = 1'b0;
	logic sleeping = 1'b0, irqWake = 1'b0, global_irq_enable = 1'b0;
	logic [3:0] irqWakeSource = 4'h0;
	logic [12:0] sleepPc = 13'h0000, pcLoad, pc;
	logic supplyPowerOk, belowBrownoutThreshold, ext_reset_n, oscTick;
	logic coreReset, resumeWake, pcLoadValid, extPinDriveOe;
	logic [7:0] peripheralFlags, rd;
	logic [31:0] seed = 32'h1;
	int err_total = 0, checked = 0, n, r0, rstCycles = 0, pinDrives = 0;

	rcst_top rcst_top_inst (.clk(clk), .sys_rst(sys_rst), .wbReq(wbReq), .wbRsp(wbRsp), .cfg(cfg),
		.supplyPowerOk(supplyPowerOk), .belowBrownoutThreshold(belowBrownoutThreshold),
		.ext_reset_n(ext_reset_n), .watchdogTimeout(watchdogTimeout), .sleeping(sleeping),
		.oscTick(oscTick), .irqWake(irqWake), .irqWakeSource(irqWakeSource),
		.global_irq_enable(global_irq_enable), .sleepPc(sleepPc), .coreReset(coreReset),
		.resumeWake(resumeWake), .pcLoad(pcLoad), .pcLoadValid(pcLoadValid),
		.peripheralFlags(peripheralFlags), .extPinDriveOe(extPinDriveOe));
	rcst_far_side #(.OSC_DIV(2)) rcst_far_side_inst (.clk(clk), .supplyCmd(supplyCmd),
		.brownCmd(brownCmd), .pinCmd(pinCmd), .supplyPowerOk(supplyPowerOk),
		.belowBrownoutThreshold(belowBrownoutThreshold), .ext_reset_n(ext_reset_n), .oscTick(oscTick));

	always #50 clk = ~clk;

	// Reset time and pin drive are tallied every cycle so short pulses are not missed
	always @(posedge clk) begin
		if (coreReset === 1'b1) rstCycles++;
		if (extPinDriveOe !== 1'b0) pinDrives++;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [7:0] status_exp(input logic to, input logic pd);
		return {3'h0, to, pd, 3'h0};
	endfunction
	function automatic int src_bit(input int i);
		return (i == 3) ? 7 : (i == 2) ? 6 : (i == 1) ? 3 : 0;
	endfunction

	task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
			err_total++;
		end
	endtask
	task automatic cmp_range(input string what, input int lo, input int hi, input int got);
		checked++;
		if (got < lo || got > hi) begin
			$display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, got);
			err_total++;
		end
	endtask
	// One classic cycle; waits for ack with a bound, since the slave sets the pace
	task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] q);
		int k;
		k = 0;
		@(posedge clk);
		wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'h1, adr: {2'h0, idx}, dat: {24'h0, wd}};
		do begin
			@(posedge clk);
			k++;
		end while (wbRsp.ack !== 1'b1 && k < 50);
		q = wbRsp.dat[7:0];
		if (k >= 50) err_total++;
		wbReq <= '0;
	endtask
	task automatic chk_reg(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] q;
		wb(1'b0, idx, 8'h00, q);
		cmp_val($sformatf("reg %0h", idx), exp, q);
	endtask
	task automatic wait_rst(input logic lvl, input int lim, output int cnt);
		cnt = 0;
		while (coreReset !== lvl && cnt < lim) begin
			@(posedge clk);
			cnt++;
		end
		if (cnt >= lim) err_total++;
	endtask
	task automatic wait_pc(output logic [12:0] p, output int cnt);
		cnt = 0;
		do begin
			@(posedge clk);
			cnt++;
		end while (pcLoadValid !== 1'b1 && cnt < 5000);
		p = pcLoad;
		if (cnt >= 5000) err_total++;
	endtask
	task automatic pulse_pin();
		pinCmd <= 1'b0;
		repeat (20) @(posedge clk);
		pinCmd <= 1'b1;
	endtask
	task automatic give_verdict();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Hang guard, well past the longest expected run
	initial begin
		#(60000 * 100);
		err_total++;
		give_verdict();
	end

	initial begin
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (30) @(posedge clk);
		supplyCmd <= 1'b1;
		wait_pc(pc, n);
		cmp_range("por start-up", OSC_STARTUP_COUNTER - 8, OSC_STARTUP_COUNTER + 40, n);
		cmp_val("por pc", 13'h0, pc);
		wait_rst(1'b0, 10, n);
		chk_reg(STA, status_exp(1'b1, 1'b1));
		chk_reg(PCN, 8'h00);
		wb(1'b1, PCN, 8'h03, rd);
		chk_reg(PCN, 8'h03);
		// Glitches of one to three cycles, two short of the five-cycle filter
		r0 = rstCycles;
		repeat (4) begin
			pinCmd <= 1'b0;
			repeat (xs() % 3 + 1) @(posedge clk);
			pinCmd <= 1'b1;
			repeat (8) @(posedge clk);
		end
		cmp_val("glitch reset", r0, rstCycles);
		cfg.extResetPinSelect <= 1'b0;
		pulse_pin();
		repeat (5) @(posedge clk);
		cmp_val("pin ignored", r0, rstCycles);
		cfg.extResetPinSelect <= 1'b1;
		pulse_pin();
		wait_rst(1'b0, 40, n);
		cmp_range("pin release", 0, 10, n);
		cmp_val("pin reset", 1'b1, rstCycles > r0);
		chk_reg(STA, status_exp(1'b1, 1'b1));
		watchdogTimeout <= 1'b1;
		@(posedge clk);
		watchdogTimeout <= 1'b0;
		wait_rst(1'b1, 20, n);
		wait_rst(1'b0, 4000, n);
		cmp_range("wdt release", 0, 40, n);
		chk_reg(STA, status_exp(1'b0, 1'b1));
		chk_reg(PCN, 8'h03);
		sleeping <= 1'b1;
		@(posedge clk);
		pinCmd <= 1'b0;
		wait_rst(1'b1, 20, n);
		sleeping <= 1'b0;
		repeat (20) @(posedge clk);
		pinCmd <= 1'b1;
		wait_rst(1'b0, 40, n);
		chk_reg(STA, status_exp(1'b1, 1'b0));
		// Brown-out in every crystal code, then external and internal clock
		for (int i = 0; i < 5; i++) begin
			cfg.oscSelect <= 3'(i);
			wb(1'b1, PCN, 8'h03, rd);
			brownCmd <= 1'b1;
			wait_rst(1'b1, 20, n);
			brownCmd <= 1'b0;
			wait_rst(1'b0, 4000, n);
			cmp_range("bod start-up", (i < 3) ? OSC_STARTUP_COUNTER - 8 : 0, (i < 3) ? OSC_STARTUP_COUNTER + 40 : 40, n);
			chk_reg(PCN, 8'h02);
			chk_reg(STA, status_exp(1'b1, 1'b1));
		end
		cfg.oscSelect <= rcst_pkg::RCST_OSC_XT;
		sleeping <= 1'b1;
		sleepPc <= 13'(xs());
		@(posedge clk);
		watchdogTimeout <= 1'b1;
		@(posedge clk);
		watchdogTimeout <= 1'b0;
		wait_pc(pc, n);
		sleeping <= 1'b0;
		cmp_range("wake start-up", OSC_STARTUP_COUNTER - 8, OSC_STARTUP_COUNTER + 40, n);
		cmp_val("wdt wake pc", sleepPc + 13'h1, pc);
		chk_reg(STA, status_exp(1'b0, 1'b0));
		chk_reg(PCN, 8'h02);
		for (int i = 0; i < 4; i++) begin
			sleeping <= 1'b1;
			sleepPc <= 13'(xs());
			irqWakeSource <= 4'h1 << i;
			@(posedge clk);
			irqWake <= 1'b1;
			@(posedge clk);
			irqWake <= 1'b0;
			wait_pc(pc, n);
			sleeping <= 1'b0;
			cmp_val("irq wake pc", sleepPc + 13'h1, pc);
			chk_reg(STA, status_exp(1'b1, 1'b0));
			cmp_val("wake flag", 1'b1, peripheralFlags[src_bit(i)]);
		end
		cmp_val("pin drive", 0, pinDrives);
		give_verdict();
	end
endmodule
